// ===== core/tcm_apb_if.sv
`timescale 1ns/100ps
interface tcm_apb_if;
    import tcm_map_pkg::*;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
    logic              core_local_mem_read_block;
    logic              core_restart;

    modport device (
        input  psel, penable, pwrite, paddr, pwdata,
        input  core_local_mem_read_block, core_restart,
        output prdata, pready, pslverr
    );
    modport loader (
        output psel, penable, pwrite, paddr, pwdata,
        output core_local_mem_read_block, core_restart,
        input  prdata, pready, pslverr
    );
endinterface : tcm_apb_if

// ===== core/tcm_core_router.sv
`timescale 1ns/100ps
// How it works
// [R01] local window goes to tightly coupled memory
// [R02] upper window leaves through the wide master
// [R03] peripheral window leaves through the peripheral master
// [R04] outside master reads memory as APB master
// [R05] slave port accepts loader writes into memory
// [R06] block input high stalls core memory reads
// [R07] block input honoured only with slave port
// [R08] core restart clears core-side state and port logic; memory keeps its contents
// [R09] loader may restart core after loading
// [R10] nonvolatile boot maps wide window at 0x7000_0000
// [R11] block low means ordinary core reads
module tcm_core_router
    import tcm_map_pkg::*;
#(
    parameter int MEM_WORDS   = LMEM_WORDS,
    parameter bit SLAVE_PORT  = 1'b1,
    parameter bit NV_BOOT     = 1'b0
)(
    // clock and reset
    input  wire logic              mclk_i,
    input  wire logic              reset_n_i,
    // core request
    input  wire logic              core_valid_i,
    input  wire logic              core_write_i,
    input  wire logic [ADDR_W-1:0] core_addr_i,
    input  wire logic [DATA_W-1:0] core_wdata_i,
    output logic                   core_done_o,
    output logic                   core_err_o,
    output logic [DATA_W-1:0]      core_rdata_o,
    // outgoing windows
    output logic                   wide_req_o,
    output logic                   peri_req_o,
    output logic                   ext_write_o,
    output logic [ADDR_W-1:0]      ext_addr_o,
    output logic [DATA_W-1:0]      ext_wdata_o,
    input  wire logic              ext_done_i,
    input  wire logic              ext_err_i,
    input  wire logic [DATA_W-1:0] ext_rdata_i,
    // local memory slave port
    tcm_apb_if.device              apb
);
    localparam int IDX_W = $clog2(MEM_WORDS);

    if (MEM_WORDS < 2 || (MEM_WORDS << WORD_LSB) >
        int'(LMEM_LAST - LMEM_BASE) + 1) begin : g_bad_words
        $error("MEM_WORDS does not fit the local window");
    end

    typedef enum logic [2:0] {
        CS_IDLE  = 3'h1,
        CS_LOCAL = 3'h2,
        CS_EXT   = 3'h4
    } core_state_t;

    logic [DATA_W-1:0] mem [MEM_WORDS];
    core_state_t       state, next_state;
    logic              done, next_done, err, next_err;
    logic [DATA_W-1:0] rdata, next_rdata;
    logic              wreq, next_wreq, preq, next_preq;
    logic              xwr, next_xwr;
    logic [ADDR_W-1:0] xaddr, next_xaddr, laddr, next_laddr;
    logic [DATA_W-1:0] xwd, next_xwd;
    logic              lwr, next_lwr;
    logic              pready, next_pready, pslverr, next_pslverr;
    logic [DATA_W-1:0] prdata, next_prdata;
    region_t           region;
    logic              read_block, restart, wide_base_hit;
    logic              p_setup, p_hit, p_wr;
    logic [IDX_W-1:0]  p_idx, l_idx;
    logic              mem_we;
    logic [IDX_W-1:0]  mem_idx;
    logic [DATA_W-1:0] mem_wd;

    // without the slave port the gating pin does not exist
    assign read_block = SLAVE_PORT && apb.core_local_mem_read_block; // [R07]
    assign restart    = apb.core_restart;

    // address decode
    always_comb begin
        wide_base_hit = NV_BOOT ?
            (core_addr_i >= NVB_BASE && core_addr_i <= NVB_LAST) :   // [R10]
            (core_addr_i >= WIDE_BASE && core_addr_i <= WIDE_LAST);  // [R02]
        if (core_addr_i >= LMEM_BASE && core_addr_i <= LMEM_LAST)
            region = RG_LOCAL;                                        // [R01]
        else if (wide_base_hit)
            region = RG_WIDE;
        else if (core_addr_i >= PERI_BASE && core_addr_i <= PERI_LAST)
            region = RG_PERI;                                         // [R03]
        else
            region = RG_NONE;
    end

    assign l_idx   = laddr[WORD_LSB +: IDX_W];
    assign p_idx   = apb.paddr[WORD_LSB +: IDX_W];
    assign p_setup = SLAVE_PORT && apb.psel && !apb.penable;
    assign p_hit   = apb.paddr >= LMEM_BASE && apb.paddr <= LMEM_LAST &&
                     apb.paddr[WORD_LSB +: ADDR_W - WORD_LSB] <
                     (ADDR_W - WORD_LSB)'(MEM_WORDS) +
                     LMEM_BASE[WORD_LSB +: ADDR_W - WORD_LSB];
    // loader write commits in the access phase
    assign p_wr    = SLAVE_PORT && apb.psel && apb.penable && pready &&
                     apb.pwrite && !pslverr && !restart;             // [R05]

    // single write port: loader write wins, core write waits a cycle
    always_comb begin
        mem_we  = p_wr;
        mem_idx = p_idx;
        mem_wd  = apb.pwdata;
        if (!p_wr && state == CS_LOCAL && lwr && !restart) begin
            mem_we  = 1'b1;
            mem_idx = l_idx;
            mem_wd  = xwd;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (mem_we)
            mem[mem_idx] <= mem_wd;
    end

    // core side
    always_comb begin
        next_state = state;
        next_done  = 1'b0;
        next_err   = 1'b0;
        next_rdata = rdata;
        next_wreq  = 1'b0;
        next_preq  = 1'b0;
        next_xwr   = xwr;
        next_xaddr = xaddr;
        next_xwd   = xwd;
        next_laddr = laddr;
        next_lwr   = lwr;
        unique case (state)
            CS_IDLE: begin
                if (core_valid_i) begin
                    unique case (region)
                        RG_LOCAL: begin
                            next_state = CS_LOCAL;
                            next_laddr = core_addr_i;
                            next_lwr   = core_write_i;
                            next_xwd   = core_wdata_i;
                        end
                        RG_WIDE, RG_PERI: begin
                            next_state = CS_EXT;
                            next_wreq  = region == RG_WIDE;
                            next_preq  = region == RG_PERI;
                            next_xwr   = core_write_i;
                            next_xaddr = core_addr_i;
                            next_xwd   = core_wdata_i;
                        end
                        default: begin
                            next_done = 1'b1;
                            next_err  = 1'b1;
                        end
                    endcase
                end
            end
            CS_LOCAL: begin
                if (lwr) begin
                    if (!p_wr) begin
                        next_state = CS_IDLE;
                        next_done  = 1'b1;
                    end
                end else if (!read_block) begin                       // [R06]
                    next_state = CS_IDLE;                              // [R11]
                    next_done  = 1'b1;
                    next_rdata = mem[l_idx];
                end
            end
            CS_EXT: begin
                if (ext_done_i) begin
                    next_state = CS_IDLE;
                    next_done  = 1'b1;
                    next_err   = ext_err_i;
                    next_rdata = xwr ? rdata : ext_rdata_i;
                end
            end
            default: next_state = CS_IDLE;
        endcase
        if (restart) begin                                            // [R08]
            next_state = CS_IDLE;
            next_done  = 1'b0;
            next_err   = 1'b0;
            next_wreq  = 1'b0;
            next_preq  = 1'b0;
        end
    end

    // slave port, zero wait states; no port gives an error answer
    always_comb begin
        next_pready  = 1'b0;
        next_pslverr = 1'b0;
        next_prdata  = prdata;
        if (apb.psel && !apb.penable) begin
            next_pready  = 1'b1;
            next_pslverr = !SLAVE_PORT || !p_hit;
            if (p_setup && p_hit && !apb.pwrite)
                next_prdata = mem[p_idx];                              // [R04]
        end
        if (restart) begin                                            // [R08]
            next_pready  = 1'b0;
            next_pslverr = 1'b0;
            next_prdata  = DATA_ZERO;
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state   <= CS_IDLE;
            done    <= 1'b0;
            err     <= 1'b0;
            rdata   <= DATA_ZERO;
            wreq    <= 1'b0;
            preq    <= 1'b0;
            xwr     <= 1'b0;
            xaddr   <= LMEM_BASE;
            xwd     <= DATA_ZERO;
            laddr   <= LMEM_BASE;
            lwr     <= 1'b0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= DATA_ZERO;
        end else begin
            state   <= next_state;
            done    <= next_done;
            err     <= next_err;
            rdata   <= next_rdata;
            wreq    <= next_wreq;
            preq    <= next_preq;
            xwr     <= next_xwr;
            xaddr   <= next_xaddr;
            xwd     <= next_xwd;
            laddr   <= next_laddr;
            lwr     <= next_lwr;
            pready  <= next_pready;
            pslverr <= next_pslverr;
            prdata  <= next_prdata;
        end
    end

    assign core_done_o  = done;
    assign core_err_o   = err;
    assign core_rdata_o = rdata;
    assign wide_req_o   = wreq;
    assign peri_req_o   = preq;
    assign ext_write_o  = xwr;
    assign ext_addr_o   = xaddr;
    assign ext_wdata_o  = xwd;
    assign apb.pready   = pready;
    assign apb.pslverr  = pslverr;
    assign apb.prdata   = prdata;
endmodule : tcm_core_router

// ===== core/tcm_loader.sv
`timescale 1ns/100ps
module tcm_loader
    import tcm_map_pkg::*;
(
    // clock and reset
    input  wire logic              mclk_i,
    input  wire logic              reset_n_i,
    // command side
    input  wire logic              cmd_valid_i,
    input  wire logic              cmd_write_i,
    input  wire logic [ADDR_W-1:0] cmd_addr_i,
    input  wire logic [DATA_W-1:0] cmd_wdata_i,
    input  wire logic              hold_core_i,
    input  wire logic              restart_core_i,
    output logic                   cmd_ready_o,
    output logic                   done_o,
    output logic                   err_o,
    output logic [DATA_W-1:0]      rdata_o,
    // slave port of the local memory
    tcm_apb_if.loader              apb
);
    typedef enum logic [2:0] {
        LD_IDLE   = 3'h1,
        LD_SETUP  = 3'h2,
        LD_ACCESS = 3'h4
    } ld_state_t;

    ld_state_t         state, next_state;
    logic              psel, next_psel, penable, next_penable;
    logic              pwrite, next_pwrite;
    logic [ADDR_W-1:0] paddr, next_paddr;
    logic [DATA_W-1:0] pwdata, next_pwdata, rdata, next_rdata;
    logic              done, next_done, err, next_err;
    logic              block, next_block, restart, next_restart;

    always_comb begin
        next_state   = state;
        next_psel    = psel;
        next_penable = penable;
        next_pwrite  = pwrite;
        next_paddr   = paddr;
        next_pwdata  = pwdata;
        next_rdata   = rdata;
        next_done    = 1'b0;
        next_err     = 1'b0;
        next_block   = hold_core_i;     // [R06]
        next_restart = restart_core_i;  // [R09]
        unique case (state)
            LD_IDLE: begin
                if (cmd_valid_i) begin  // [R04]
                    next_state  = LD_SETUP;
                    next_psel   = 1'b1;
                    next_pwrite = cmd_write_i;
                    next_paddr  = cmd_addr_i;
                    next_pwdata = cmd_wdata_i;  // [R05]
                end
            end
            LD_SETUP: begin
                next_state   = LD_ACCESS;
                next_penable = 1'b1;
            end
            LD_ACCESS: begin
                // port logic is held in restart and never answers
                if (restart) begin  // [R08]
                    next_state   = LD_IDLE;
                    next_psel    = 1'b0;
                    next_penable = 1'b0;
                    next_done    = 1'b1;
                    next_err     = 1'b1;
                end else if (apb.pready) begin
                    next_state   = LD_IDLE;
                    next_psel    = 1'b0;
                    next_penable = 1'b0;
                    next_done    = 1'b1;
                    next_err     = apb.pslverr;
                    next_rdata   = pwrite ? rdata : apb.prdata;
                end
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state   <= LD_IDLE;
            psel    <= 1'b0;
            penable <= 1'b0;
            pwrite  <= 1'b0;
            paddr   <= LMEM_BASE;
            pwdata  <= DATA_ZERO;
            rdata   <= DATA_ZERO;
            done    <= 1'b0;
            err     <= 1'b0;
            block   <= 1'b0;
            restart <= 1'b0;
        end else begin
            state   <= next_state;
            psel    <= next_psel;
            penable <= next_penable;
            pwrite  <= next_pwrite;
            paddr   <= next_paddr;
            pwdata  <= next_pwdata;
            rdata   <= next_rdata;
            done    <= next_done;
            err     <= next_err;
            block   <= next_block;
            restart <= next_restart;
        end
    end

    assign apb.psel                      = psel;
    assign apb.penable                   = penable;
    assign apb.pwrite                    = pwrite;
    assign apb.paddr                     = paddr;
    assign apb.pwdata                    = pwdata;
    assign apb.core_local_mem_read_block = block;
    assign apb.core_restart              = restart;
    // ready is decoded from the whole state register: idle state only
    assign cmd_ready_o = state == LD_IDLE;
    assign done_o      = done;
    assign err_o       = err;
    assign rdata_o     = rdata;
endmodule : tcm_loader

// ===== core/tcm_map_pkg.sv
package tcm_map_pkg;
    localparam int          ADDR_W         = 32;
    localparam int          DATA_W         = 32;
    // local memory window
    localparam logic [31:0] LMEM_BASE      = 32'h8000_0000;
    localparam logic [31:0] LMEM_LAST      = 32'h8000_FFFF;
    localparam int          LMEM_WORDS     = 16384;
    localparam int          WORD_LSB       = 2;
    // wide master window, base configuration
    localparam logic [31:0] WIDE_BASE      = 32'h8001_0000;
    localparam logic [31:0] WIDE_LAST      = 32'h8FFF_FFFF;
    // wide master window, nonvolatile-boot configuration
    localparam logic [31:0] NVB_BASE       = 32'h7000_0000;
    localparam logic [31:0] NVB_LAST       = 32'h700F_FFFF;
    // peripheral window
    localparam logic [31:0] PERI_BASE      = 32'h6000_0000;
    localparam logic [31:0] PERI_LAST      = 32'h6FFF_FFFF;
    localparam logic [31:0] DATA_ZERO      = 32'h0000_0000;

    typedef enum logic [3:0] {
        RG_NONE  = 4'h1,
        RG_LOCAL = 4'h2,
        RG_WIDE  = 4'h4,
        RG_PERI  = 4'h8
    } region_t;
endpackage : tcm_map_pkg

// ===== verif/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    import tcm_map_pkg::*;
    localparam logic [31:0] EXT_DATA = 32'hA5A5_0F0F;
    localparam int          LIMIT    = 2000;
    logic              mclk_i, reset_n_i, core_valid_i, core_write_i;
    logic              core_done_o, core_err_o, wide_req_o, peri_req_o;
    logic [ADDR_W-1:0] core_addr_i, ext_addr_o, cmd_addr_i;
    logic [DATA_W-1:0] core_wdata_i, core_rdata_o, cmd_wdata_i, rdata_o, rd;
    logic              ext_done_i, ext_err_i, ext_fail, er, ext_write_o;
    logic [DATA_W-1:0] ext_wdata_o;
    logic              nvb_done, nvb_wide, nvb_peri, nvb_ext_done;
    logic              cmd_valid_i, cmd_write_i, cmd_ready_o, done_o, err_o;
    logic              hold_core_i, restart_core_i;
    int                mismatches, checks, cycles, n_wide, n_peri, lat;
    int                n_nvb, n_nvb_done;

    tcm_apb_if u_tcm_apb_if ();
    tcm_core_router u_tcm_core_router (
        .mclk_i, .reset_n_i, .core_valid_i, .core_write_i, .core_addr_i,
        .core_wdata_i, .core_done_o, .core_err_o, .core_rdata_o,
        .wide_req_o, .peri_req_o, .ext_write_o, .ext_addr_o,
        .ext_wdata_o, .ext_done_i, .ext_err_i, .ext_rdata_i(EXT_DATA),
        .apb(u_tcm_apb_if)
    );
    tcm_loader u_tcm_loader (
        .mclk_i, .reset_n_i, .cmd_valid_i, .cmd_write_i, .cmd_addr_i,
        .cmd_wdata_i, .hold_core_i, .restart_core_i, .cmd_ready_o,
        .done_o, .err_o, .rdata_o, .apb(u_tcm_apb_if)
    );
    tcm_apb_properties #(.MEM_WORDS(LMEM_WORDS)) u_tcm_apb_properties (
        .mclk_i, .reset_n_i,
        .psel(u_tcm_apb_if.psel), .penable(u_tcm_apb_if.penable),
        .pwrite(u_tcm_apb_if.pwrite), .paddr(u_tcm_apb_if.paddr),
        .pwdata(u_tcm_apb_if.pwdata), .prdata(u_tcm_apb_if.prdata),
        .pready(u_tcm_apb_if.pready), .pslverr(u_tcm_apb_if.pslverr),
        .core_local_mem_read_block(u_tcm_apb_if.core_local_mem_read_block),
        .core_restart(u_tcm_apb_if.core_restart)
    );

    // second router: nonvolatile boot map, no slave port
    tcm_apb_if u_nvb_apb_if ();
    assign u_nvb_apb_if.psel         = 1'b0;
    assign u_nvb_apb_if.penable      = 1'b0;
    assign u_nvb_apb_if.pwrite       = 1'b0;
    assign u_nvb_apb_if.paddr        = LMEM_BASE;
    assign u_nvb_apb_if.pwdata       = DATA_ZERO;
    assign u_nvb_apb_if.core_restart = 1'b0;
    // gating pin follows the first router but must be ignored here
    assign u_nvb_apb_if.core_local_mem_read_block =
        u_tcm_apb_if.core_local_mem_read_block;
    tcm_core_router #(.SLAVE_PORT(1'b0), .NV_BOOT(1'b1))
        u_tcm_core_router_nvb (
        .mclk_i, .reset_n_i, .core_valid_i, .core_write_i, .core_addr_i,
        .core_wdata_i, .core_done_o(nvb_done), .core_err_o(),
        .core_rdata_o(), .wide_req_o(nvb_wide), .peri_req_o(nvb_peri),
        .ext_write_o(), .ext_addr_o(), .ext_wdata_o(),
        .ext_done_i(nvb_ext_done), .ext_err_i(1'b0),
        .ext_rdata_i(EXT_DATA), .apb(u_nvb_apb_if)
    );

    always #25 mclk_i = ~mclk_i;

    // fabric answers each outgoing request one cycle later
    always @(posedge mclk_i) begin
        ext_done_i <= wide_req_o | peri_req_o;
        ext_err_i  <= (wide_req_o | peri_req_o) & ext_fail;
        if (wide_req_o === 1'b1) n_wide++;
        if (peri_req_o === 1'b1) n_peri++;
        nvb_ext_done <= nvb_wide | nvb_peri;
        if (nvb_wide === 1'b1) n_nvb++;
        if (nvb_done === 1'b1) n_nvb_done++;
        cycles++;
        if (cycles == LIMIT) begin
            mismatches++;
            conclude();
        end
    end

    task conclude();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude

    task chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: word %h not %h", $time, got, exp);
        end
    endtask : chk_word

    task chk_flag(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: flag %b not %b", $time, got, exp);
        end
    endtask : chk_flag

    // bounded wait: an aborted request leaves lat at 20
    task core_op(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        core_valid_i <= 1'b1;
        core_write_i <= w;
        core_addr_i  <= a;
        core_wdata_i <= d;
        @(posedge mclk_i);
        core_valid_i <= 1'b0;
        // an unmapped answer is launched at the taking edge itself
        lat = 1;
        #1;
        while (core_done_o !== 1'b1 && lat < 20) begin
            @(posedge mclk_i);
            lat++;
            #1;
        end
        rd = core_rdata_o;
        er = core_err_o;
    endtask : core_op

    task ld_op(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk_i);
        cmd_valid_i <= 1'b1;
        cmd_write_i <= w;
        cmd_addr_i  <= a;
        cmd_wdata_i <= d;
        @(posedge mclk_i);
        cmd_valid_i <= 1'b0;
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
            #1;
        end while (done_o !== 1'b1 && n < 20);
        rd = rdata_o;
        er = err_o;
    endtask : ld_op

    task t_map();
        logic [31:0] ad [8] = '{32'h5FFF_FFFC, 32'h6000_0000, 32'h6FFF_FFFC,
            32'h7000_0000, 32'h8000_FFFC, 32'h8001_0000, 32'h8FFF_FFFC,
            32'h9000_0000};
        region_t rg [8] = '{RG_NONE, RG_PERI, RG_PERI, RG_NONE, RG_LOCAL,
            RG_WIDE, RG_WIDE, RG_NONE};
        int w0, p0, v0;
        for (int i = 0; i < 8; i++) begin
            w0 = n_wide;
            p0 = n_peri;
            v0 = n_nvb;
            core_op(1'b0, ad[i], 32'h0);
            chk_flag(er, rg[i] == RG_NONE);
            chk_word(32'(n_wide - w0), 32'(rg[i] == RG_WIDE));
            chk_word(32'(n_peri - p0), 32'(rg[i] == RG_PERI));
            if (rg[i] == RG_LOCAL) chk_word(32'(lat), 32'h2);
            if (rg[i] == RG_NONE) chk_word(32'(lat), 32'h1);
            if (rg[i] == RG_WIDE || rg[i] == RG_PERI) begin
                chk_word(rd, EXT_DATA);
                chk_word(ext_addr_o, ad[i]);
            end
            // the second router may still be busy on its own window
            repeat (3) @(posedge mclk_i);
            chk_word(32'(n_nvb - v0), 32'(ad[i] == NVB_BASE));
        end
        core_op(1'b1, 32'h8001_0010, 32'h3C3C_A5A5);
        chk_flag(ext_write_o, 1'b1);
        chk_word(ext_addr_o, 32'h8001_0010);
        chk_word(ext_wdata_o, 32'h3C3C_A5A5);
        ext_fail = 1'b1;
        core_op(1'b0, 32'h6000_0100, 32'h0);
        chk_flag(er, 1'b1);
        ext_fail = 1'b0;
        $display("t_map finished");
    endtask : t_map

    task t_load();
        chk_flag(cmd_ready_o, 1'b1);
        ld_op(1'b1, 32'h8000_0040, 32'h1234_5678);
        chk_flag(er, 1'b0);
        ld_op(1'b0, 32'h8000_0040, 32'h0);
        chk_word(rd, 32'h1234_5678);
        core_op(1'b0, 32'h8000_0040, 32'h0);
        chk_word(rd, 32'h1234_5678);
        chk_word(32'(lat), 32'h2);
        core_op(1'b1, 32'h8000_0044, 32'h0BAD_F00D);
        ld_op(1'b0, 32'h8000_0044, 32'h0);
        chk_word(rd, 32'h0BAD_F00D);
        ld_op(1'b1, 32'h8001_0000, 32'h5555_5555);
        chk_flag(er, 1'b1);
        $display("t_load finished");
    endtask : t_load

    // loader fills memory while the core is gated, not held in reset
    task t_block();
        int d0;
        @(posedge mclk_i);
        hold_core_i <= 1'b1;
        ld_op(1'b1, 32'h8000_0048, 32'hCAFE_0001);
        d0 = n_nvb_done;
        fork
            core_op(1'b0, 32'h8000_0048, 32'h0);
            begin
                repeat (10) @(posedge mclk_i);
                chk_word(32'(n_nvb_done - d0), 32'h1);
                hold_core_i <= 1'b0;
            end
        join
        chk_word(rd, 32'hCAFE_0001);
        chk_flag(lat > 8 && lat < 20, 1'b1);
        $display("t_block finished");
    endtask : t_block

    task t_restart();
        @(posedge mclk_i);
        restart_core_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        core_op(1'b0, 32'h8000_0040, 32'h0);
        chk_word(32'(lat), 32'h14);
        ld_op(1'b1, 32'h8000_0040, 32'hDEAD_BEEF);
        chk_flag(er, 1'b1);
        chk_flag(cmd_ready_o, 1'b1);
        @(posedge mclk_i);
        restart_core_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        ld_op(1'b0, 32'h8000_0040, 32'h0);
        chk_word(rd, 32'h1234_5678);
        core_op(1'b0, 32'h8000_0040, 32'h0);
        chk_word(rd, 32'h1234_5678);
        $display("t_restart finished");
    endtask : t_restart

    initial begin
        mclk_i = 1'b0;
        reset_n_i = 1'b0;
        {core_valid_i, core_write_i, cmd_valid_i, cmd_write_i} = 4'h0;
        ext_fail = 1'b0;
        {hold_core_i, restart_core_i} = 2'h0;
        core_addr_i = 32'h0;
        core_wdata_i = 32'h0;
        cmd_addr_i = 32'h0;
        cmd_wdata_i = 32'h0;
        repeat (5) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        t_map();
        t_load();
        t_block();
        t_restart();
        conclude();
    end
endmodule : tb_top

// ===== verif/tcm_apb_properties.sv
`timescale 1ns/100ps
module tcm_apb_properties
    import tcm_map_pkg::*;
#(
    parameter int MEM_WORDS = LMEM_WORDS
)(
    // clock and reset
    input wire logic              mclk_i,
    input wire logic              reset_n_i,
    // slave port wires
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              core_local_mem_read_block,
    input wire logic              core_restart
);
    localparam logic [31:0] MEM_LAST = LMEM_BASE + 32'(MEM_WORDS * 4 - 1);
    logic in_mem;
    assign in_mem = (paddr >= LMEM_BASE) && (paddr <= MEM_LAST);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);

    a_setup_answer: assert property (
        psel && !penable && !core_restart |=> psel && penable && pready)
        else $error("no ready after setup");
    a_ready_access: assert property (
        pready |-> psel && penable) else $error("ready outside access");
    a_ready_single: assert property (
        pready |=> !pready && !penable) else $error("ready held");
    a_enable_setup: assert property (
        $rose(penable) |-> psel && $past(psel)) else $error("no setup");
    a_addr_held: assert property (
        psel && penable |-> $stable(paddr) && $stable(pwrite)
            && $stable(pwdata)) else $error("request moved in access");
    a_range_error: assert property (
        pready && !in_mem |-> pslverr) else $error("outside access taken");
    a_range_ok: assert property (
        pready && in_mem |-> !pslverr) else $error("inside access refused");
    a_error_paired: assert property (
        pslverr |-> pready) else $error("error without ready");
    a_restart_clear: assert property (
        core_restart |=> !pready && !pslverr)
        else $error("port answered in restart");
endmodule : tcm_apb_properties
